// *** src/fcs_pkg.sv ***
package fcs_pkg;
  localparam int unsigned FCS_ADDR_W = 16;
  localparam logic [15:0] FCS_FLASH_STATUS_OFF = 16'h3026;
  localparam logic [15:0] FCS_CTRL_OFF = 16'h3024;
  localparam int unsigned FCS_CMD_DONE_BIT = 7;
  localparam int unsigned FCS_RSVD6_BIT = 6;
  localparam int unsigned FCS_ACC_ERR_BIT = 5;
  localparam int unsigned FCS_PROT_VIOL_BIT = 4;
  localparam int unsigned FCS_BUSY_BIT = 3;
  localparam int unsigned FCS_RSVD2_BIT = 2;
  localparam int unsigned FCS_CES_LSB = 0;
  localparam int unsigned FCS_CES_W = 2;
  localparam int unsigned FCS_IRQ_EN_BIT = 7;
  localparam logic [1:0] FCS_CES_RST = 2'h0;
  localparam logic FCS_IRQ_EN_RST = 1'b0;
  typedef enum logic [1:0] {FCS_IDLE, FCS_RUN, FCS_RESET_SEQ} fcs_state_t;
endpackage

// *** src/fcs_flash_status.sv ***
`timescale 1ns/1ps
// Overview of operation
// - done flag high idle, low running
// - writing one to done launches command
// - done stays low until finish or violation
// - access error on sequence break, bad command
// - access error blocks launch
// - access error clears on write one
// - protection flag on protected program/erase
// - protection flag clears on write one
// - protection flag blocks launch and sequence
// - busy high while controller executes
// - bits 6 and 2 read zero
// - error status set on command errors
// - reset-sequence double fault shows after reset
// - interrupt when done and enable set
module fcs_flash_status (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [fcs_pkg::FCS_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic seq_break,
  input wire logic bad_cmd,
  input wire logic prot_hit,
  input wire logic seq_start_req,
  output logic seq_start_ok,
  output logic cmd_launch,
  input wire logic cmd_finish,
  input wire logic [fcs_pkg::FCS_CES_W-1:0] cmd_err,
  input wire logic rst_seq_done,
  input wire logic [fcs_pkg::FCS_CES_W-1:0] rst_seq_err,
  output logic busy,
  output logic irq
);
  import fcs_pkg::*;

  fcs_state_t state_ff, nxt_state;
  logic acc_err_ff, nxt_acc_err;
  logic prot_ff, nxt_prot;
  logic [FCS_CES_W-1:0] ces_ff, nxt_ces;
  logic irq_en_ff, nxt_irq_en;
  logic [7:0] rdata_ff, nxt_rdata;

  if (FCS_CES_LSB + FCS_CES_W > FCS_RSVD2_BIT) begin : g_bad_ces
    $error("error status field overlaps bit 2");
  end
  if (FCS_ADDR_W < 16) begin : g_bad_addr
    $error("address too narrow for register offsets");
  end

  function automatic logic addr_hit(input logic [FCS_ADDR_W-1:0] a, input logic [FCS_ADDR_W-1:0] off);
    return a == off;
  endfunction

  wire sel_stat = addr_hit(addr, FCS_FLASH_STATUS_OFF);
  wire sel_ctrl = addr_hit(addr, FCS_CTRL_OFF);
  wire wr_stat = wr_stb && sel_stat;
  wire wr_ctrl = wr_stb && sel_ctrl;
  wire idle = state_ff == FCS_IDLE;
  wire cmd_done = idle;
  wire launch = wr_stat && wdata[FCS_CMD_DONE_BIT] && idle && !acc_err_ff && !prot_ff;
  wire violation = prot_hit || bad_cmd;

  wire [7:0] stat_word = {cmd_done, 1'b0, acc_err_ff, prot_ff, busy, 1'b0, ces_ff};

  assign busy = state_ff == FCS_RUN;
  assign cmd_launch = launch;
  assign seq_start_ok = seq_start_req && !prot_ff;
  assign irq = irq_en_ff && cmd_done;
  assign rdata = rdata_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FCS_RESET_SEQ: begin
        if (rst_seq_done) begin
          nxt_state = FCS_IDLE;
        end
      end
      FCS_IDLE: begin
        if (launch) begin
          nxt_state = FCS_RUN;
        end
      end
      FCS_RUN: begin
        if (cmd_finish || violation) begin
          nxt_state = FCS_IDLE;
        end
      end
      default: nxt_state = FCS_IDLE;
    endcase
  end

  // set wins over a clearing write
  assign nxt_acc_err = (seq_break || bad_cmd) ? 1'b1 :
                       (wr_stat && wdata[FCS_ACC_ERR_BIT]) ? 1'b0 : acc_err_ff;
  assign nxt_prot = prot_hit ? 1'b1 :
                    (wr_stat && wdata[FCS_PROT_VIOL_BIT]) ? 1'b0 : prot_ff;

  always_comb begin
    nxt_ces = ces_ff;
    if (state_ff == FCS_RESET_SEQ && rst_seq_done) begin
      nxt_ces = rst_seq_err;
    end else if (launch) begin
      nxt_ces = FCS_CES_RST;
    end else if (busy && cmd_finish) begin
      nxt_ces = cmd_err;
    end
  end

  assign nxt_irq_en = wr_ctrl ? wdata[FCS_IRQ_EN_BIT] : irq_en_ff;
  assign nxt_rdata = !rd_stb ? 8'h00 :
                     sel_stat ? stat_word :
                     sel_ctrl ? {irq_en_ff, 7'h00} : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= FCS_RESET_SEQ;
      acc_err_ff <= 1'b0;
      prot_ff <= 1'b0;
      ces_ff <= FCS_CES_RST;
      irq_en_ff <= FCS_IRQ_EN_RST;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      acc_err_ff <= nxt_acc_err;
      prot_ff <= nxt_prot;
      ces_ff <= nxt_ces;
      irq_en_ff <= nxt_irq_en;
      rdata_ff <= nxt_rdata;
    end
  end

  sequence s_launch_wr;
    wr_stat && wdata[FCS_CMD_DONE_BIT] && idle && !acc_err_ff && !prot_ff;
  endsequence

  sequence s_run_end;
    busy && (cmd_finish || violation);
  endsequence

  sequence s_finish;
    busy && cmd_finish;
  endsequence

  sequence s_rd_stat;
    rd_stb && sel_stat;
  endsequence

  sequence s_rd_ctrl;
    rd_stb && sel_ctrl;
  endsequence

  sequence s_reset_exit;
    state_ff == FCS_RESET_SEQ && rst_seq_done;
  endsequence

  sequence s_acc_one;
    wr_stat && wdata[FCS_ACC_ERR_BIT];
  endsequence

  sequence s_prot_one;
    wr_stat && wdata[FCS_PROT_VIOL_BIT];
  endsequence

  AST_DONE_NOT_BUSY: assert property (
    @(posedge clk) disable iff (!rst_b)
    !(cmd_done && busy)
  )
    else $error("done and busy both high");

  AST_RESET_SEQ_QUIET: assert property (
    @(posedge clk) disable iff (!rst_b)
    state_ff == FCS_RESET_SEQ |-> !cmd_done && !busy
  )
    else $error("done or busy during reset sequence");

  AST_STAT_DONE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rd_stat |=> rdata[FCS_CMD_DONE_BIT] == $past(cmd_done)
  )
    else $error("read done bit wrong");

  AST_LAUNCH_PULSE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_launch_wr |-> cmd_launch
  )
    else $error("launch write did not start command");

  AST_LAUNCH_CLEARS: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_launch_wr |=> !cmd_done && busy
  )
    else $error("launch did not clear done");

  AST_NO_LAUNCH_BUSY: assert property (
    @(posedge clk) disable iff (!rst_b)
    !idle |-> !cmd_launch
  )
    else $error("launch while not idle");

  AST_HOLD_LOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    busy && !cmd_finish && !violation |=> busy && !cmd_done
  )
    else $error("done rose early");

  AST_FINISH_SETS: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_run_end |=> cmd_done && !busy
  )
    else $error("done not set at finish");

  AST_ACC_SET: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_break |=> acc_err_ff
  )
    else $error("access error not set");

  AST_ACC_BAD_CMD: assert property (
    @(posedge clk) disable iff (!rst_b)
    bad_cmd |=> acc_err_ff
  )
    else $error("access error not set on bad command");

  AST_ACC_BLOCK: assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_err_ff |-> !cmd_launch
  )
    else $error("launch with access error");

  AST_ACC_CLR: assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_err_ff && wr_stat && !wdata[FCS_ACC_ERR_BIT] |=> acc_err_ff
  )
    else $error("zero write cleared access error");

  AST_ACC_ONE_CLR: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_acc_one ##0 (!seq_break && !bad_cmd) |=> !acc_err_ff
  )
    else $error("access error not cleared");

  AST_PROT_SET: assert property (
    @(posedge clk) disable iff (!rst_b)
    prot_hit |=> prot_ff
  )
    else $error("protection flag not set");

  AST_PROT_CLR: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_prot_one ##0 !prot_hit |=> !prot_ff
  )
    else $error("protection flag not cleared");

  AST_PROT_ZERO: assert property (
    @(posedge clk) disable iff (!rst_b)
    prot_ff && wr_stat && !wdata[FCS_PROT_VIOL_BIT] |=> prot_ff
  )
    else $error("zero write cleared protection flag");

  AST_PROT_BLOCK: assert property (
    @(posedge clk) disable iff (!rst_b)
    prot_ff |-> !cmd_launch && !seq_start_ok
  )
    else $error("start with protection flag");

  AST_SEQ_GRANT: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_start_req && !prot_ff |-> seq_start_ok
  )
    else $error("sequence start refused without flag");

  AST_BUSY_START: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(busy) |-> $past(cmd_launch)
  )
    else $error("busy without launch");

  AST_STAT_BUSY: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rd_stat |=> rdata[FCS_BUSY_BIT] == $past(busy)
  )
    else $error("read busy bit wrong");

  AST_RSVD: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rd_stat |=> rdata[FCS_RSVD6_BIT] == 1'b0 && rdata[FCS_RSVD2_BIT] == 1'b0
  )
    else $error("reserved bits nonzero");

  AST_CES_FINISH: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_finish |=> ces_ff == $past(cmd_err)
  )
    else $error("error status not captured at finish");

  AST_CES_RESET: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_reset_exit |=> ces_ff == $past(rst_seq_err)
  )
    else $error("reset sequence error not captured");

  AST_CES_READ: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rd_stat |=> rdata[FCS_CES_LSB +: FCS_CES_W] == $past(ces_ff)
  )
    else $error("read error status wrong");

  AST_CES_IDLE_HOLD: assert property (
    @(posedge clk) disable iff (!rst_b)
    idle && !launch |=> $stable(ces_ff)
  )
    else $error("error status changed while idle");

  AST_CES_RUN_HOLD: assert property (
    @(posedge clk) disable iff (!rst_b)
    busy && !cmd_finish |=> $stable(ces_ff)
  )
    else $error("error status changed while running");

  AST_IRQ: assert property (
    @(posedge clk) disable iff (!rst_b)
    irq == (irq_en_ff && cmd_done)
  )
    else $error("irq mismatch");

  AST_CTRL_RD: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rd_ctrl |=> rdata[FCS_IRQ_EN_BIT] == $past(irq_en_ff)
  )
    else $error("read irq enable wrong");
endmodule

// *** dv/fcs_flash_status_tb_top.sv ***
`timescale 1ns/1ps
module fcs_flash_status_tb_top;
  import fcs_pkg::*;
  logic clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, srq = 1, rsd = 0;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic [3:0] ev = 0;
  logic [1:0] cerr = 0, rerr = 2'h3;
  logic ok, launch, busy, irq;
  int n_errors = 0, tests_run = 0, cyc = 0;
  localparam logic [15:0] ST = FCS_FLASH_STATUS_OFF;
  fcs_flash_status dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .seq_break(ev[0]), .bad_cmd(ev[1]), .prot_hit(ev[2]),
    .seq_start_req(srq), .seq_start_ok(ok), .cmd_launch(launch), .cmd_finish(ev[3]), .cmd_err(cerr),
    .rst_seq_done(rsd), .rst_seq_err(rerr), .busy(busy), .irq(irq));
  initial forever #4 clk = ~clk;
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d, logic l);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    #1 chk(launch, l);
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // one-cycle event pulse
  task automatic pl(int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(ST, 8'h00);
    wr(ST, 8'h80, 1'b0);
    @(posedge clk);
    rsd <= 1'b1;
    @(posedge clk);
    rsd <= 1'b0;
    rd(ST, 8'h83);
    wr(FCS_CTRL_OFF, 8'h80, 1'b0);
    rd(FCS_CTRL_OFF, 8'h80);
    wr(16'h3025, 8'hff, 1'b0);
    rd(16'h3025, 8'h00);
    wr(ST, 8'h80, 1'b1);
    #1 chk(busy, 1'b1);
    chk(irq, 1'b0);
    rd(ST, 8'h08);
    cerr <= 2'h1;
    pl(3);
    rd(ST, 8'h81);
    chk(irq, 1'b1);
    pl(0);
    rd(ST, 8'ha1);
    wr(ST, 8'h80, 1'b0);
    wr(ST, 8'h47, 1'b0);
    rd(ST, 8'ha1);
    wr(ST, 8'h20, 1'b0);
    rd(ST, 8'h81);
    pl(2);
    #1 chk(ok, 1'b0);
    rd(ST, 8'h91);
    wr(ST, 8'h80, 1'b0);
    wr(ST, 8'h10, 1'b0);
    #1 chk(ok, 1'b1);
    srq <= 1'b0;
    #1 chk(ok, 1'b0);
    srq <= 1'b1;
    rd(ST, 8'h81);
    wr(ST, 8'h80, 1'b1);
    pl(1);
    #1 chk(busy, 1'b0);
    chk(irq, 1'b1);
    summarize();
  end
endmodule
